/* design/cpu_pkg.sv */
package cpu_pkg;
	// Timing base: system clock and the safety check rate
	localparam int unsigned CPU_CLK_HZ = 10_000_000;
	localparam int unsigned CPU_CHECK_HZ = 100;
	localparam int unsigned CPU_TICK_CYC = CPU_CLK_HZ / CPU_CHECK_HZ;
	localparam int unsigned CPU_TICK_MS = 1000 / CPU_CHECK_HZ;
	// Times in ms and their counts in check ticks
	localparam int unsigned CPU_HOLD_MS = 1000;
	localparam int unsigned CPU_HOLD_TICKS = CPU_HOLD_MS / CPU_TICK_MS;
	localparam int unsigned CPU_BLINK_MS = 1000;
	localparam int unsigned CPU_BLINK_TICKS = CPU_BLINK_MS / CPU_TICK_MS;
	localparam int unsigned CPU_STUCK_MS = 5000;
	localparam int unsigned CPU_STUCK_TICKS = CPU_STUCK_MS / CPU_TICK_MS;
	// Register offsets and reset values
	localparam logic [7:0] CPU_CTRL_OFS = 8'h00;
	localparam logic [7:0] CPU_STATUS_OFS = 8'h04;
	localparam logic [31:0] CPU_CTRL_RST = 32'h0000_000a;
	// Control field positions
	localparam int CPU_F_PROFILE = 0;
	localparam int CPU_F_PCOUNT = 1;
	localparam int CPU_F_IGNDRV = 4;
	localparam int CPU_F_TWOACT = 5;
	localparam int CPU_F_JOYSEL = 6;
	localparam int CPU_F_LIMIT = 7;
	localparam int CPU_F_TRIP = 8;
	// Setting range and trip code of a joystick fault
	localparam logic [2:0] CPU_MAX_STEP = 3'h5;
	localparam logic [3:0] CPU_JOY_TRIP = 4'h7;
	// Joystick thresholds (deflection magnitude)
	localparam logic [7:0] CPU_FULL_TH = 8'h70;
	localparam logic [7:0] CPU_CENTRE_TH = 8'h08;
	localparam logic [7:0] CPU_SIDE_TH = 8'h40;
	// Lock / unlock gesture states
	typedef enum logic [2:0] {
		CPU_G_IDLE = 3'b000,
		CPU_G_HOLD = 3'b001,
		CPU_G_REL = 3'b010,
		CPU_G_FWD = 3'b011,
		CPU_G_REV = 3'b100,
		CPU_G_CEN = 3'b101
	} cpu_gest_t;
endpackage

/* design/cpu_ui.sv */
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps
// Summary of operation
// - Holding power one second beeps and arms lock gesture after release.
// - Armed lock: beep on forward, beep on reverse, long beep at centre, locked.
// - Locked at switch-on: ripple speed indicator, inhibit driving until unlocked.
// - Unlock gesture ends with long beep at release, then driving allowed.
// - Five speed steps, step one slowest, step five fastest.
// - Profile operation offers a programmable number of profiles, at most five.
// - Decrease press lowers step or selects lower profile.
// - Increase press raises step or selects higher profile.
// - Option ignores increase and decrease while the chair is driven.
// - Horn sounds while the debounced horn button is held.
// - One actuator: either button toggles adjust mode, both LEDs lit.
// - Two actuators: button selects its channel, lights its LED, routes joystick.
// - Selected button returns to drive; opposite button switches channel.
// - Optionally, sideways joystick switches channel in two-actuator adjust mode.
// - Gauge blinks at switch-on, then steady after one second without fault.
// - Off-centre joystick at switch-on inhibits motion, ripples gauge until release.
// - Five seconds of start-up deflection latches inhibit, rapid flash until reset.
// - Brakes requested whenever the joystick is at centre.
// - Speed demand rises with deflection, scaled by current step or profile.
// - Safety monitoring runs at one hundred checks per second.
// - Speed indicator also shows speed limitation and locked state.
// - Speed mode lights step count from left; profile lights single LED.
// - Active speed limitation flashes the speed indicator.
// - Trip flashes trip-code bars; joystick fault uses code seven.
module cpu_ui import cpu_pkg::*; #(
	parameter int unsigned TICK_CYC = CPU_TICK_CYC,
	parameter int unsigned SHORT_BEEP_TICKS = 10,
	parameter int unsigned LONG_BEEP_TICKS = 50
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic pwr_btn_i,
	input wire logic horn_btn_i,
	input wire logic dec_btn_i,
	input wire logic inc_btn_i,
	input wire logic act_l_btn_i,
	input wire logic act_r_btn_i,
	input wire logic signed [7:0] joy_x_i,
	input wire logic signed [7:0] joy_y_i,
	input wire logic [3:0] battery_bars_i,
	input wire logic lock_restore_i,
	output logic beep_o,
	output logic horn_o,
	output logic [9:0] gauge_led_o,
	output logic [4:0] speed_led_o,
	output logic [1:0] act_led_o,
	output logic act_adjust_o,
	output logic act_sel_o,
	output logic signed [7:0] act_drive_o,
	output logic motion_inhibit_o,
	output logic brake_req_o,
	output logic [9:0] speed_demand_o,
	output logic locked_o
);

	////////////////////////////////////////////////////////////////////////
	// Decoders for the indicators; thermo shared by both, onehot for speed only
	function automatic logic [9:0] thermo(input logic [3:0] n);
		logic [9:0] r;
		r = 10'h000;
		for (int k = 0; k < 10; k++) begin
			r[k] = (4'(k) < n);
		end
		return r;
	endfunction

	function automatic logic [9:0] onehot(input logic [3:0] n);
		logic [9:0] r;
		r = 10'h000;
		for (int k = 0; k < 10; k++) begin
			r[k] = (4'(k + 1) == n);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Check tick divider, one pulse per 10 ms
	logic [16:0] tick_cnt;
	logic [7:0] phase;
	wire tick = (tick_cnt == 17'(TICK_CYC - 1));

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			tick_cnt <= 17'h0_0000;
			phase <= 8'h00;
		end else if (tick) begin
			tick_cnt <= 17'h0_0000;
			phase <= phase + 8'h01;
		end else begin
			tick_cnt <= tick_cnt + 17'h0_0001;
		end
	end

	// Flash and ripple phases derived from the tick counter
	wire flash_fast = phase[3];
	wire flash_slow = phase[5];
	wire [2:0] rip3 = phase[7] ? ~phase[6:4] : phase[6:4];
	wire [3:0] rip_pos = {1'b0, rip3} + 4'h1;

	////////////////////////////////////////////////////////////////////////
	// Button debounce: two equal samples one tick apart
	wire [5:0] btn_raw = {act_r_btn_i, act_l_btn_i, inc_btn_i, dec_btn_i,
		horn_btn_i, pwr_btn_i};
	logic [5:0] btn_samp;
	logic [5:0] btn_db;
	logic [5:0] btn_q;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_deb
			always_ff @(posedge clk_sys_i) begin
				if (!reset_n_i) begin
					btn_samp[gi] <= 1'b0;
					btn_db[gi] <= 1'b0;
				end else if (tick) begin
					btn_samp[gi] <= btn_raw[gi];
					if (btn_samp[gi] == btn_raw[gi]) begin
						btn_db[gi] <= btn_raw[gi];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			btn_q <= 6'h00;
		end else begin
			btn_q <= btn_db;
		end
	end

	// Single press pulses
	wire [5:0] press = btn_db & ~btn_q;
	wire pwr_held = btn_db[0];
	wire dec_press = press[2];
	wire inc_press = press[3];
	wire actl_press = press[4];
	wire actr_press = press[5];

	////////////////////////////////////////////////////////////////////////
	// Joystick classification
	wire [7:0] ax = joy_x_i[7] ? 8'(-joy_x_i) : 8'(joy_x_i);
	wire [7:0] ay = joy_y_i[7] ? 8'(-joy_y_i) : 8'(joy_y_i);
	wire [7:0] mag = (ax > ay) ? ax : ay;
	wire joy_centre = (ax < CPU_CENTRE_TH) && (ay < CPU_CENTRE_TH);
	wire joy_fwd = !joy_y_i[7] && (ay >= CPU_FULL_TH);
	wire joy_rev = joy_y_i[7] && (ay >= CPU_FULL_TH);
	wire joy_side = (ax >= CPU_SIDE_TH);

	////////////////////////////////////////////////////////////////////////
	// APB register file
	logic [31:0] ctrl;
	wire sel_ctrl = (paddr_i == CPU_CTRL_OFS);
	wire sel_stat = (paddr_i == CPU_STATUS_OFS);
	wire mapped = sel_ctrl || sel_stat;
	wire wr_ctrl = psel_i && penable_i && pwrite_i && sel_ctrl;
	wire cfg_profile = ctrl[CPU_F_PROFILE];
	wire [2:0] cfg_pcount = ctrl[CPU_F_PCOUNT +: 3];
	wire cfg_igndrv = ctrl[CPU_F_IGNDRV];
	wire cfg_twoact = ctrl[CPU_F_TWOACT];
	wire cfg_joysel = ctrl[CPU_F_JOYSEL];
	wire cfg_limit = ctrl[CPU_F_LIMIT];
	wire [3:0] cfg_trip = ctrl[CPU_F_TRIP +: 4];
	logic [31:0] status;

	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;

	// Control write in the access phase, read data capture in the setup phase
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			ctrl <= CPU_CTRL_RST;
			prdata_o <= 32'h0000_0000;
		end else begin
			if (wr_ctrl) begin
				ctrl <= {20'h0_0000, pwdata_i[11:0]};
			end
			if (psel_i && !penable_i) begin
				prdata_o <= sel_ctrl ? ctrl : (sel_stat ? status : 32'h0000_0000);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start-up window and joystick interlock
	logic [6:0] su_ticks;
	logic [8:0] stuck_ticks;
	logic su_active;
	logic trip_latch;
	logic started;
	wire su_win = (su_ticks < 7'(CPU_BLINK_TICKS));

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			su_ticks <= 7'h00;
		end else if (tick && su_win) begin
			su_ticks <= su_ticks + 7'h01;
		end
	end

	// Deflection in the window inhibits; five seconds of it latches
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			su_active <= 1'b0;
			stuck_ticks <= 9'h000;
			trip_latch <= 1'b0;
		end else begin
			if (su_win && !joy_centre) begin
				su_active <= 1'b1;
			end else if (joy_centre) begin
				su_active <= 1'b0;
			end
			// Each new deflection in the window starts its own five second count
			if (!su_active) begin
				stuck_ticks <= 9'h000;
			end else if (tick) begin
				stuck_ticks <= stuck_ticks + 9'h001;
			end
			if (su_active && stuck_ticks >= 9'(CPU_STUCK_TICKS - 1) && tick) begin
				trip_latch <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lock / unlock gesture machine
	cpu_gest_t gest;
	cpu_gest_t next_gest;
	logic [6:0] hold_ticks;
	logic locked;
	logic next_short;
	logic next_long;

	always_comb begin
		next_gest = gest;
		next_short = 1'b0;
		next_long = 1'b0;
		case (gest)
			CPU_G_IDLE: begin
				if (locked) begin
					next_gest = CPU_G_FWD;
				end else if (pwr_held) begin
					next_gest = CPU_G_HOLD;
				end
			end
			CPU_G_HOLD: begin
				if (!pwr_held) begin
					next_gest = CPU_G_IDLE;
				end else if (hold_ticks >= 7'(CPU_HOLD_TICKS)) begin
					next_gest = CPU_G_REL;
					next_short = 1'b1;
				end
			end
			CPU_G_REL: begin
				if (!pwr_held) begin
					next_gest = CPU_G_FWD;
				end
			end
			CPU_G_FWD: begin
				if (joy_fwd) begin
					next_gest = CPU_G_REV;
					next_short = 1'b1;
				end
			end
			CPU_G_REV: begin
				if (joy_rev) begin
					next_gest = CPU_G_CEN;
					next_short = 1'b1;
				end
			end
			CPU_G_CEN: begin
				if (joy_centre) begin
					next_gest = CPU_G_IDLE;
					next_long = 1'b1;
				end
			end
			default: begin
				next_gest = CPU_G_IDLE;
			end
		endcase
	end

	// Gesture state, hold timer and lock flag
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			gest <= CPU_G_IDLE;
			hold_ticks <= 7'h00;
			locked <= 1'b0;
			started <= 1'b0;
		end else begin
			started <= 1'b1;
			gest <= next_gest;
			if (gest != CPU_G_HOLD) begin
				hold_ticks <= 7'h00;
			end else if (tick) begin
				hold_ticks <= hold_ticks + 7'h01;
			end
			if (!started) begin
				locked <= lock_restore_i;
			end else if (next_long) begin
				locked <= !locked;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Beeper: short and long beeps counted in ticks
	logic [7:0] beep_cnt;

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			beep_cnt <= 8'h00;
		end else if (next_long) begin
			beep_cnt <= 8'(LONG_BEEP_TICKS);
		end else if (next_short) begin
			beep_cnt <= 8'(SHORT_BEEP_TICKS);
		end else if (tick && beep_cnt != 8'h00) begin
			beep_cnt <= beep_cnt - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Actuator mode and channel selection
	logic adj;
	logic sel_r;
	logic side_q;
	wire side_edge = joy_side && !side_q;

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			adj <= 1'b0;
			sel_r <= 1'b0;
			side_q <= 1'b0;
		end else begin
			side_q <= joy_side;
			if (!cfg_twoact) begin
				if (actl_press || actr_press) begin
					adj <= !adj;
				end
			end else if (!adj) begin
				if (actl_press || actr_press) begin
					adj <= 1'b1;
					sel_r <= actr_press;
				end
			end else if ((actl_press && !sel_r) || (actr_press && sel_r)) begin
				adj <= 1'b0;
			end else if (actl_press || actr_press) begin
				sel_r <= actr_press;
			end else if (cfg_joysel && side_edge) begin
				sel_r <= !sel_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Speed step or profile selection
	logic [2:0] setting;
	wire inhibit = locked || su_active || trip_latch || (gest != CPU_G_IDLE);
	wire driving = !joy_centre && !inhibit && !adj;
	wire btn_ok = !(cfg_igndrv && driving);
	wire [2:0] top = cfg_profile ?
		((cfg_pcount > CPU_MAX_STEP || cfg_pcount == 3'h0) ?
		CPU_MAX_STEP : cfg_pcount) : CPU_MAX_STEP;

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			setting <= 3'h1;
		end else if (setting > top) begin
			setting <= top;
		end else if (btn_ok && inc_press && setting < top) begin
			setting <= setting + 3'h1;
		end else if (btn_ok && dec_press && setting > 3'h1) begin
			setting <= setting - 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Indicator patterns
	wire [3:0] set4 = {1'b0, setting};
	wire [9:0] set_oh = onehot(set4);
	wire [9:0] set_th = thermo(set4);
	wire [4:0] set_pat = cfg_profile ? set_oh[4:0] : set_th[4:0];
	wire [9:0] bat_pat = thermo(battery_bars_i);
	wire [3:0] trip_code = trip_latch ? CPU_JOY_TRIP : cfg_trip;
	// Speed ripple folds back at the fifth LED so one LED is always lit
	wire [3:0] rip_spd = (rip_pos > 4'h5) ? (4'ha - rip_pos) : rip_pos;
	wire [9:0] rip_oh = onehot(rip_spd);
	// Gauge ripple spans three to ten bars, never wrapping to none
	wire [9:0] rip_g = thermo(rip_pos + 4'h2);

	// Speed indicator: ripple, flash, or setting
	assign speed_led_o = locked ? rip_oh[4:0] :
		(cfg_limit ? (flash_slow ? set_pat : 5'h00) :
		set_pat);

	// Battery gauge: trip, interlock ripple, start-up blink, level
	assign gauge_led_o = (trip_code != 4'h0) ?
		(flash_fast ? thermo(trip_code) : 10'h000) :
		(su_active ? rip_g :
		(su_win ? (flash_fast ? bat_pat : 10'h000) : bat_pat));

	////////////////////////////////////////////////////////////////////////
	// Motion outputs
	wire stop = inhibit || (trip_code != 4'h0);
	// Full magnitude kept so a full reverse stroke is not read as zero
	wire [9:0] demand = {2'b00, mag} * {7'h00, setting};

	assign motion_inhibit_o = stop;
	assign brake_req_o = joy_centre || stop;
	assign speed_demand_o = (stop || adj || joy_centre) ? 10'h000 : demand;
	assign act_adjust_o = adj;
	assign act_sel_o = sel_r;
	assign act_drive_o = (adj && !stop) ? joy_y_i : 8'sh00;
	assign act_led_o = !adj ? 2'h0 : (!cfg_twoact ? 2'h3 :
		(sel_r ? 2'h2 : 2'h1));
	assign beep_o = (beep_cnt != 8'h00);
	assign horn_o = btn_db[1];
	assign locked_o = locked;
	assign status = {21'h00_0000, gest, sel_r, adj, setting, su_active,
		trip_latch, locked};

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_rev_done;
		gest == CPU_G_CEN && joy_centre;
	endsequence

	a_horn_follows: assert property ($changed(horn_o) |->
		horn_o == $past(horn_btn_i))
		else $error("horn changed against the button");
	a_lock_inhibit: assert property (locked |-> motion_inhibit_o)
		else $error("locked chair not inhibited");
	a_trip_latch_holds: assert property (trip_latch |=> trip_latch)
		else $error("start-up trip latch released");
	a_centre_brake: assert property (joy_centre |-> brake_req_o)
		else $error("no brake request at centre");
	a_long_beep_len: assert property (s_rev_done |=>
		beep_cnt == 8'(LONG_BEEP_TICKS) && locked != $past(locked))
		else $error("gesture end without long beep and lock change");
	a_inc_raises: assert property (started && btn_ok && inc_press &&
		setting < top |=> setting == $past(setting) + 3'h1)
		else $error("increase press did not raise setting");
	a_dec_lowers: assert property (started && btn_ok && dec_press &&
		!inc_press && setting > 3'h1 && setting <= top
		|=> setting == $past(setting) - 3'h1)
		else $error("decrease press did not lower setting");
	a_step_range: assert property (setting >= 3'h1 &&
		setting <= CPU_MAX_STEP)
		else $error("setting out of range");
	a_one_act_leds: assert property (adj && !cfg_twoact |->
		act_led_o == 2'h3)
		else $error("single actuator mode LEDs wrong");
	a_trip_code: assert property (trip_latch |->
		gauge_led_o == (flash_fast ? 10'h07f : 10'h000))
		else $error("joystick trip not shown as seven bars");

endmodule

/* tb/cpu_operator.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Operator at the panel: six buttons and a self-centring joystick
module cpu_operator (
	input wire logic clk_i,
	output logic [5:0] btn_o,
	output logic signed [7:0] joy_x_o,
	output logic signed [7:0] joy_y_o
);
	// Hands off the panel at power-up
	initial begin
		btn_o = 6'h00;
		joy_x_o = 8'h00;
		joy_y_o = 8'h00;
	end
	// Hold one button for a chosen time, then let go and pause
	task automatic press(input int idx, input int hold);
		@(posedge clk_i);
		btn_o[idx] <= 1'b1;
		repeat (hold) @(posedge clk_i);
		btn_o[idx] <= 1'b0;
		repeat (60) @(posedge clk_i);
	endtask
	// Deflect the stick; zero means released, it springs to centre
	task automatic joy(input logic signed [7:0] x, input logic signed [7:0] y);
		@(posedge clk_i);
		joy_x_o <= x;
		joy_y_o <= y;
		repeat (40) @(posedge clk_i);
	endtask
endmodule

/* tb/test_chair_panel_ui_fsm.sv */
`timescale 1ns/100ps
module test_chair_panel_ui_fsm;
	import cpu_pkg::*;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, restore;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [3:0] bars;
	logic [5:0] btn;
	logic signed [7:0] jx, jy, act_drive;
	logic beep, horn, act_adj, act_sel, inhibit, brake, locked, e, hit, mv;
	logic [9:0] gauge, demand;
	logic [4:0] speed_led;
	logic [1:0] act_led;
	int failures, checked, n;
	////////////////////////////////////////////////////////////////////////////
	// Block under test, with a short check tick for simulation
	cpu_ui #(.TICK_CYC(10)) dut (.clk_sys_i(clk), .reset_n_i(reset_n),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .pwr_btn_i(btn[0]),
		.horn_btn_i(btn[1]), .dec_btn_i(btn[2]), .inc_btn_i(btn[3]),
		.act_l_btn_i(btn[4]), .act_r_btn_i(btn[5]), .joy_x_i(jx),
		.joy_y_i(jy), .battery_bars_i(bars), .lock_restore_i(restore),
		.beep_o(beep), .horn_o(horn), .gauge_led_o(gauge),
		.speed_led_o(speed_led), .act_led_o(act_led), .act_adjust_o(act_adj),
		.act_sel_o(act_sel), .act_drive_o(act_drive),
		.motion_inhibit_o(inhibit), .brake_req_o(brake),
		.speed_demand_o(demand), .locked_o(locked));
	cpu_operator op (.clk_i(clk), .btn_o(btn), .joy_x_o(jx), .joy_y_o(jy));
	// 10 MHz system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Power cycle: reset low for five edges
	task automatic do_reset(input logic r);
		@(posedge clk);
		reset_n <= 1'b0;
		restore <= r;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// One APB transfer; held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Length in cycles of the next beep
	task automatic beep_len(output int len);
		int w;
		w = 0;
		len = 0;
		while (beep !== 1'b1 && w < 1500) begin
			@(posedge clk);
			w++;
		end
		while (beep === 1'b1) begin
			@(posedge clk);
			len++;
		end
	endtask
	// Watch gauge or speed LEDs: value v seen, and any change
	task automatic watch(input int cyc, input bit g, input logic [9:0] v);
		logic [9:0] s, f;
		f = g ? gauge : {5'h00, speed_led};
		hit = 1'b0;
		mv = 1'b0;
		repeat (cyc) begin
			@(posedge clk);
			s = g ? gauge : {5'h00, speed_led};
			hit |= (s === v);
			mv |= (s !== f);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		apb(0, 8'h00, 0, d, e);
		check(d, 32'h0000_000a);
		apb(0, 8'h04, 0, d, e);
		check(d[5:3], 3'h1);
		apb(1, 8'h00, 32'hffff_000a, d, e);
		apb(1, 8'h04, 32'hffff_ffff, d, e);
		apb(0, 8'h00, 0, d, e);
		check(d, 32'h0000_000a);
		apb(0, 8'h04, 0, d, e);
		check(d[0], 1'b0);
		apb(0, 8'h10, 0, d, e);
		check(d, 32'h0000_0000);
		check(e, 1'b1);
	endtask
	task automatic t_steps;
		check(speed_led, 5'h01);
		for (int i = 2; i <= 5; i++) begin
			op.press(3, 60);
			check(speed_led, 32'((1 << i) - 1));
		end
		op.press(3, 60);
		check(speed_led, 5'h1f);
		op.press(2, 400);
		check(speed_led, 5'h0f);
		repeat (4) op.press(2, 60);
		check(speed_led, 5'h01);
	endtask
	task automatic t_profile;
		apb(1, 8'h00, 32'h0000_0007, d, e);
		repeat (3) op.press(3, 60);
		check(speed_led, 5'h04);
		op.press(2, 60);
		check(speed_led, 5'h02);
		apb(1, 8'h00, 32'h0000_000a, d, e);
		@(posedge clk);
		check(speed_led, 5'h03);
		// Speed limited and an external trip three: both indicators flash
		apb(1, 8'h00, 32'h0000_038a, d, e);
		watch(700, 1'b0, 10'h003);
		check({hit, mv}, 2'h3);
		watch(200, 1'b1, 10'h007);
		check({hit, mv, inhibit}, 3'h7);
		apb(1, 8'h00, 32'h0000_000a, d, e);
	endtask
	task automatic t_horn;
		check(horn, 1'b0);
		fork
			op.press(1, 300);
			begin
				repeat (100) @(posedge clk);
				check(horn, 1'b1);
			end
		join
		check(horn, 1'b0);
	endtask
	task automatic t_drive;
		check(brake, 1'b1);
		op.joy(8'h00, 8'h20);
		check({brake, demand}, 11'h040);
		op.joy(8'h00, 8'h40);
		check(demand, 10'h080);
		op.joy(8'hb0, 8'h10);
		check(demand, 10'h0a0);
		apb(1, 8'h00, 32'h0000_001a, d, e);
		op.press(3, 60);
		apb(0, 8'h04, 0, d, e);
		check(d[5:3], 3'h2);
		op.joy(8'h00, 8'h00);
		check({brake, demand}, 11'h400);
		op.press(3, 60);
		check(speed_led, 5'h07);
	endtask
	task automatic t_act;
		apb(1, 8'h00, 32'h0000_000a, d, e);
		op.press(4, 60);
		check({act_adj, act_led}, 3'h7);
		op.joy(8'h00, 8'h30);
		check({act_drive, demand}, 18'h0c000);
		op.joy(8'h00, 8'h00);
		op.press(5, 60);
		check({act_adj, act_led}, 3'h0);
		apb(1, 8'h00, 32'h0000_006a, d, e);
		op.press(4, 60);
		check({act_adj, act_sel, act_led}, 4'h9);
		op.press(5, 60);
		check({act_adj, act_sel, act_led}, 4'he);
		op.joy(8'hb0, 8'h00);
		op.joy(8'h00, 8'h00);
		check({act_adj, act_sel, act_led}, 4'h9);
		op.press(4, 60);
		check({act_adj, act_led}, 3'h0);
		apb(1, 8'h00, 32'h0000_000a, d, e);
	endtask
	// Forward, reverse, release: two short beeps then a long one
	task automatic gesture;
		fork
			op.joy(8'h00, 8'h70);
			beep_len(n);
		join
		check(n > 50 && n < 200, 1'b1);
		fork
			op.joy(8'h00, 8'h90);
			beep_len(n);
		join
		check(n > 50 && n < 200, 1'b1);
		fork
			op.joy(8'h00, 8'h00);
			beep_len(n);
		join
		check(n > 400, 1'b1);
	endtask
	task automatic t_lock;
		fork
			op.press(0, 1200);
			beep_len(n);
		join
		check(n > 50 && n < 200, 1'b1);
		gesture();
		check(locked, 1'b1);
		do_reset(1'b1);
		check({locked, inhibit}, 2'h3);
		watch(3000, 1'b0, 10'h000);
		check(mv, 1'b1);
		gesture();
		check({locked, inhibit}, 2'h0);
	endtask
	task automatic t_startup;
		do_reset(1'b0);
		watch(1000, 1'b1, 10'h01f);
		check({hit, mv}, 2'h3);
		watch(400, 1'b1, 10'h01f);
		check({hit, mv}, 2'h2);
		op.joy(8'h00, 8'h30);
		do_reset(1'b0);
		watch(600, 1'b1, 10'h01f);
		check({inhibit, mv}, 2'h3);
		op.joy(8'h00, 8'h00);
		check(inhibit, 1'b0);
		op.joy(8'h00, 8'h30);
		do_reset(1'b0);
		repeat (5300) @(posedge clk);
		op.joy(8'h00, 8'h00);
		op.joy(8'h00, 8'h30);
		op.joy(8'h00, 8'h00);
		apb(0, 8'h04, 0, d, e);
		check({inhibit, d[1]}, 2'h3);
		watch(400, 1'b1, 10'h07f);
		check({hit, mv}, 2'h3);
		do_reset(1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		failures = 0;
		checked = 0;
		reset_n = 1'b0;
		restore = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		bars = 4'h5;
		do_reset(1'b0);
		t_regs();
		t_steps();
		t_profile();
		t_horn();
		t_drive();
		t_act();
		t_lock();
		t_startup();
		summarize();
	end
	// Watchdog well beyond the expected run of about 18000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		summarize();
	end
endmodule
